// ### irq_vec_pkg.sv
package irq_vec_pkg;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [7:0] OFS_MASK   = 8'h00;
	localparam logic [7:0] OFS_FLAGS  = 8'h04;
	localparam logic [7:0] OFS_CLEAR  = 8'h08;
	localparam logic [7:0] OFS_BSC    = 8'h0C;
	localparam logic [7:0] OFS_ROUTE  = 8'h10;
	localparam logic [7:0] OFS_VECTOR = 8'h14;

	// Mask and flag layout; reserved bits 15, 8 and 2 read as zero.
	localparam logic [15:0] IRQ_RW_BITS  = 16'h7EFB;
	localparam logic [15:0] MASK_RST     = 16'h0000;
	localparam logic [15:0] FLAGS_RST    = 16'h0000;
	localparam int          BIT_EXT0     = 0;
	localparam int          BIT_EXT1     = 1;
	localparam int          BIT_TIMER    = 3;
	localparam int          BIT_P0_RX    = 4;
	localparam int          BIT_P0_TX    = 5;
	localparam int          BIT_SLOT_58  = 6;
	localparam int          BIT_SLOT_5C  = 7;
	localparam int          BIT_HOST     = 9;
	localparam int          BIT_SLOT_68  = 10;
	localparam int          BIT_SLOT_6C  = 11;
	localparam int          BIT_DMA4     = 12;
	localparam int          BIT_DMA5     = 13;
	localparam int          BIT_CROSS    = 14;
	localparam int          NUM_BITS     = 16;

	// Vector table: locations are relative, four words per slot.
	localparam logic [7:0] LOC_RESET    = 8'h00;
	localparam logic [7:0] LOC_NMI      = 8'h04;
	localparam logic [7:0] LOC_MASKABLE = 8'h40;
	localparam logic [7:0] LOC_STEP     = 8'h04;
	localparam logic [4:0] PRIO_RESET   = 5'h01;
	localparam logic [4:0] PRIO_NMI     = 5'h02;
	localparam logic [4:0] PRIO_OFFSET  = 5'h03;

	// Selected source codes; flag bits use their own index.
	localparam logic [4:0] SEL_RESET = 5'h10;
	localparam logic [4:0] SEL_NMI   = 5'h11;
	localparam logic [4:0] SEL_NONE  = 5'h1F;

	// Field positions in the bank switch, route and vector registers.
	localparam int BSC_REQ_BIT    = 0;
	localparam int ROUTE_SLOT_58  = 0;
	localparam int ROUTE_SLOT_5C  = 1;
	localparam int ROUTE_SLOT_68  = 2;
	localparam int ROUTE_SLOT_6C  = 3;
	localparam int ROUTE_W        = 4;
	localparam int VEC_VALID_BIT  = 31;
	localparam int VEC_PRIO_LSB   = 8;

	typedef struct packed {
		logic       ext_pin_irq_zero;
		logic       ext_pin_irq_one;
		logic       timer_irq;
		logic       port0_rx_irq;
		logic       port0_tx_irq;
		logic       port1_rx_irq;
		logic       port1_tx_irq;
		logic       port2_rx_irq;
		logic       port2_tx_irq;
		logic [5:0] dma_done_irq;
		logic       host_port_irq;
		logic       cross_core_irq;
	} irq_events_s;

	typedef struct packed {
		logic       valid;
		logic [4:0] prio;
		logic [7:0] loc;
	} vector_s;

endpackage : irq_vec_pkg

// ### irq_vectoring.sv
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

//Contract
// - Fixed vector slots, four words apart, per core.
// - Reset vectors to location 00, priority 1.
// - External pin zero: location 40, priority 3.
// - External pin one: location 44, priority 4.
// - Port zero receive: location 50, priority 7.
// - Port zero transmit: location 54, priority 8.
// - Slot 58 shares port two receive, DMA 0.
// - Slot 5C shares port two transmit, DMA 1.
// - Host port request: location 64, priority 12.
// - Slot 68 shares port one receive, DMA 2.
// - Slot 6C shares port one transmit, DMA 3.
// - Incoming cross-core request sets flag bit 14.
// - Writing one to request field raises cross-core.
// - New request needs a clearing zero write first.
// - Request sets the other core's flag only.
// - Sixteen-bit mask and flags; 15, 8, 2 reserved.
// - Fixed bit layout shared by mask and flags.
module irq_vectoring #(
	parameter int ADDR_W = 8
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire logic [ADDR_W-1:0]        avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	input  wire logic [3:0]               avs_byteenable,
	output logic      [31:0]              avs_readdata,
	output logic                          avs_waitrequest,
	input  wire irq_vec_pkg::irq_events_s events,
	input  wire logic                     sw_reset,
	input  wire logic                     nmi,
	input  wire logic                     core_ack,
	output irq_vec_pkg::vector_s          vector,
	output logic                          irq,
	output logic                          cross_core_irq_out
);

	if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
		$error("ADDR_W must lie between 5 and 8");
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: every access waits exactly one cycle.

	logic                        wait_r;
	logic                        wait_nxt;
	logic [31:0]                 rdata_r;
	logic [31:0]                 rdata_nxt;
	logic [7:0]                  addr;
	logic                        wr_take;
	logic [15:0]                 wdata16;
	logic [15:0]                 mask_r;
	logic [15:0]                 mask_nxt;
	logic [15:0]                 flags_r;
	logic [15:0]                 flags_nxt;
	logic                        bsc_req_r;
	logic                        bsc_req_nxt;
	logic                        cross_r;
	logic                        cross_nxt;
	logic [irq_vec_pkg::ROUTE_W-1:0] route_r;
	logic [irq_vec_pkg::ROUTE_W-1:0] route_nxt;
	logic                        reset_pend_r;
	logic                        reset_pend_nxt;
	logic                        nmi_pend_r;
	logic                        nmi_pend_nxt;
	logic [4:0]                  sel_r;
	logic [4:0]                  sel_nxt;
	irq_vec_pkg::vector_s        vec_r;
	irq_vec_pkg::vector_s        vec_nxt;
	logic                        irq_r;
	logic                        irq_nxt;
	logic [15:0]                 set_bits;
	logic [15:0]                 clr_bits;
	logic [15:0]                 pend;

	assign addr = 8'(avs_address);
	// A write lands only at the edge where waitrequest is seen low.
	assign wr_take = avs_write && !wait_r;

	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [15:0] r;
		r = old_v;
		if (be[0]) begin
			r[7:0] = new_v[7:0];
		end
		if (be[1]) begin
			r[15:8] = new_v[15:8];
		end
		return r;
	endfunction : merge16

	always_comb begin
		wait_nxt = 1'b1;
		if ((avs_read || avs_write) && wait_r) begin
			wait_nxt = 1'b0;
		end
	end

	always_comb begin
		rdata_nxt = '0;
		if (avs_read && wait_r) begin
			unique case (addr)
				irq_vec_pkg::OFS_MASK:
					rdata_nxt = 32'(mask_r);
				irq_vec_pkg::OFS_FLAGS:
					rdata_nxt = 32'(flags_r);
				irq_vec_pkg::OFS_BSC:
					rdata_nxt[irq_vec_pkg::BSC_REQ_BIT] = bsc_req_r;
				irq_vec_pkg::OFS_ROUTE:
					rdata_nxt = 32'(route_r);
				irq_vec_pkg::OFS_VECTOR: begin
					rdata_nxt[irq_vec_pkg::VEC_VALID_BIT] = vec_r.valid;
					rdata_nxt[irq_vec_pkg::VEC_PRIO_LSB +: 5] = vec_r.prio;
					rdata_nxt[7:0] = vec_r.loc;
				end
				default:
					rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_r  <= 1'b1;
			rdata_r <= '0;
		end else begin
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// Control registers: mask, route, bank switch request field.

	assign wdata16 = merge16(16'h0000, avs_writedata, avs_byteenable);

	always_comb begin
		mask_nxt    = mask_r;
		route_nxt   = route_r;
		bsc_req_nxt = bsc_req_r;
		cross_nxt   = 1'b0;
		if (wr_take) begin
			unique case (addr)
				irq_vec_pkg::OFS_MASK:
					mask_nxt = merge16(mask_r, avs_writedata, avs_byteenable)
						& irq_vec_pkg::IRQ_RW_BITS;
				irq_vec_pkg::OFS_ROUTE:
					if (avs_byteenable[0]) begin
						route_nxt = avs_writedata[irq_vec_pkg::ROUTE_W-1:0];
					end
				irq_vec_pkg::OFS_BSC:
					if (avs_byteenable[0]) begin
						bsc_req_nxt = avs_writedata[irq_vec_pkg::BSC_REQ_BIT];
						// Only a one after a clearing zero raises a request.
						cross_nxt = avs_writedata[irq_vec_pkg::BSC_REQ_BIT]
							&& !bsc_req_r;
					end
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_r    <= irq_vec_pkg::MASK_RST;
			route_r   <= '0;
			bsc_req_r <= 1'b0;
			cross_r   <= 1'b0;
		end else begin
			mask_r    <= mask_nxt;
			route_r   <= route_nxt;
			bsc_req_r <= bsc_req_nxt;
			cross_r   <= cross_nxt;
		end
	end

	// The pulse leaves for the other core and never touches own flags.
	assign cross_core_irq_out = cross_r;

	////////////////////////////////////////////////////////////////////////
	// Flag register: events set, software and acknowledge clear.

	always_comb begin
		set_bits = '0;
		set_bits[irq_vec_pkg::BIT_EXT0]  = events.ext_pin_irq_zero;
		set_bits[irq_vec_pkg::BIT_EXT1]  = events.ext_pin_irq_one;
		set_bits[irq_vec_pkg::BIT_TIMER] = events.timer_irq;
		set_bits[irq_vec_pkg::BIT_P0_RX] = events.port0_rx_irq;
		set_bits[irq_vec_pkg::BIT_P0_TX] = events.port0_tx_irq;
		set_bits[irq_vec_pkg::BIT_SLOT_58] =
			route_r[irq_vec_pkg::ROUTE_SLOT_58] ?
			events.dma_done_irq[0] : events.port2_rx_irq;
		set_bits[irq_vec_pkg::BIT_SLOT_5C] =
			route_r[irq_vec_pkg::ROUTE_SLOT_5C] ?
			events.dma_done_irq[1] : events.port2_tx_irq;
		set_bits[irq_vec_pkg::BIT_HOST] = events.host_port_irq;
		set_bits[irq_vec_pkg::BIT_SLOT_68] =
			route_r[irq_vec_pkg::ROUTE_SLOT_68] ?
			events.dma_done_irq[2] : events.port1_rx_irq;
		set_bits[irq_vec_pkg::BIT_SLOT_6C] =
			route_r[irq_vec_pkg::ROUTE_SLOT_6C] ?
			events.dma_done_irq[3] : events.port1_tx_irq;
		set_bits[irq_vec_pkg::BIT_DMA4]  = events.dma_done_irq[4];
		set_bits[irq_vec_pkg::BIT_DMA5]  = events.dma_done_irq[5];
		set_bits[irq_vec_pkg::BIT_CROSS] = events.cross_core_irq;
	end

	always_comb begin
		clr_bits = '0;
		if (wr_take && (addr == irq_vec_pkg::OFS_FLAGS ||
			addr == irq_vec_pkg::OFS_CLEAR)) begin
			clr_bits = wdata16;
		end
		if (core_ack && vec_r.valid && !sel_r[4]) begin
			clr_bits[sel_r[3:0]] = 1'b1;
		end
		// A set in the same cycle as its clear wins, so no event is lost.
		flags_nxt = ((flags_r & ~clr_bits) | set_bits)
			& irq_vec_pkg::IRQ_RW_BITS;
	end

	always_comb begin
		reset_pend_nxt = reset_pend_r;
		nmi_pend_nxt   = nmi_pend_r;
		if (core_ack && vec_r.valid && sel_r == irq_vec_pkg::SEL_RESET) begin
			reset_pend_nxt = 1'b0;
		end
		if (core_ack && vec_r.valid && sel_r == irq_vec_pkg::SEL_NMI) begin
			nmi_pend_nxt = 1'b0;
		end
		if (sw_reset) begin
			reset_pend_nxt = 1'b1;
		end
		if (nmi) begin
			nmi_pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_r      <= irq_vec_pkg::FLAGS_RST;
			reset_pend_r <= 1'b1;
			nmi_pend_r   <= 1'b0;
		end else begin
			flags_r      <= flags_nxt;
			reset_pend_r <= reset_pend_nxt;
			nmi_pend_r   <= nmi_pend_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Priority vectoring. Maskable slots follow the bit index upward, so
	// the lowest set bit is also the smallest priority number.

	assign pend = flags_r & mask_r;

	always_comb begin
		sel_nxt = irq_vec_pkg::SEL_NONE;
		vec_nxt = '0;
		for (int i = irq_vec_pkg::NUM_BITS - 1; i >= 0; i--) begin
			if (pend[i]) begin
				sel_nxt      = 5'(i);
				vec_nxt.valid = 1'b1;
				vec_nxt.prio = irq_vec_pkg::PRIO_OFFSET + 5'(i);
				vec_nxt.loc  = irq_vec_pkg::LOC_MASKABLE
					+ 8'(i) * irq_vec_pkg::LOC_STEP;
			end
		end
		if (nmi_pend_r) begin
			sel_nxt       = irq_vec_pkg::SEL_NMI;
			vec_nxt.valid = 1'b1;
			vec_nxt.prio  = irq_vec_pkg::PRIO_NMI;
			vec_nxt.loc   = irq_vec_pkg::LOC_NMI;
		end
		if (reset_pend_r) begin
			sel_nxt       = irq_vec_pkg::SEL_RESET;
			vec_nxt.valid = 1'b1;
			vec_nxt.prio  = irq_vec_pkg::PRIO_RESET;
			vec_nxt.loc   = irq_vec_pkg::LOC_RESET;
		end
		irq_nxt = vec_nxt.valid;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_r <= irq_vec_pkg::SEL_NONE;
			vec_r <= '0;
			irq_r <= 1'b0;
		end else begin
			sel_r <= sel_nxt;
			vec_r <= vec_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign vector = vec_r;
	assign irq    = irq_r;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_reset_first: assert property (
		rst_b && reset_pend_r |=> vec_r.valid && vec_r.loc == 8'h00
			&& vec_r.prio == 5'h01)
		else $error("reset pending but not vectored first");

	a_nmi_unmasked: assert property (
		nmi_pend_r && !reset_pend_r |=> vec_r.loc == 8'h04
			&& vec_r.prio == 5'h02)
		else $error("nmi not vectored ahead of maskable sources");

	a_ext0_slot: assert property (
		!reset_pend_r && !nmi_pend_r && pend[0]
		|=> vec_r.loc == 8'h40 && vec_r.prio == 5'h03)
		else $error("pin zero vector wrong");

	a_ext1_slot: assert property (
		!reset_pend_r && !nmi_pend_r && pend[1:0] == 2'b10
		|=> vec_r.loc == 8'h44 && vec_r.prio == 5'h04)
		else $error("pin one vector wrong");

	a_port0_slots: assert property (
		!reset_pend_r && !nmi_pend_r && pend[4:0] == 5'h10
		|=> vec_r.loc == 8'h50 && vec_r.prio == 5'h07)
		else $error("port zero receive vector wrong");

	a_cross_slot: assert property (
		!reset_pend_r && !nmi_pend_r && pend == 16'h4000
		|=> vec_r.loc == 8'h78 && vec_r.prio == 5'h11)
		else $error("cross-core vector wrong");

	a_host_slot: assert property (
		!reset_pend_r && !nmi_pend_r && pend == 16'h0200
		|=> vec_r.loc == 8'h64 && vec_r.prio == 5'h0C)
		else $error("host port vector wrong");

	a_route_dma0: assert property (
		route_r[0] && events.dma_done_irq[0] |=> flags_r[6])
		else $error("routed DMA 0 completion not flagged");

	a_cross_latch: assert property (
		events.cross_core_irq |=> flags_r[14])
		else $error("incoming cross-core request not latched");

	a_cross_fresh: assert property (
		wr_take && addr == irq_vec_pkg::OFS_BSC && avs_byteenable[0]
		&& avs_writedata[0] |=> cross_core_irq_out == !$past(bsc_req_r))
		else $error("cross-core pulse without a fresh request");

	a_cross_not_self: assert property (
		cross_core_irq_out && !$past(events.cross_core_irq)
		&& !$past(flags_r[14]) |-> !flags_r[14])
		else $error("own request set own cross-core flag");

	a_reserved_zero: assert property (
		flags_r[15] == 1'b0 && flags_r[8] == 1'b0 && mask_r[2] == 1'b0)
		else $error("reserved flag or mask bit set");

	a_bus_wait: assert property (
		(avs_read || avs_write) && wait_r |=> !wait_r ##1 wait_r)
		else $error("bus answer not after one wait cycle");

	c_cross_raise: cover property (cross_core_irq_out);
	c_nested: cover property (pend[0] && pend[14] && core_ack);
	c_nmi_ack: cover property (nmi_pend_r ##1 core_ack ##1 !nmi_pend_r);
	c_routed_dma: cover property (route_r[3] && events.dma_done_irq[3]);

endmodule : irq_vectoring

`default_nettype wire

// ### far_side_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stands for the pins, peripherals and the other core around one subsystem.
module far_side_model (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_b,
	input  wire logic                 cross_core_irq_in,
	output var  irq_vec_pkg::irq_events_s events
);
	int pulses;

	initial begin
		events = '0;
	end

	// The other core counts each request pulse it is handed.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pulses <= 0;
		end else if (cross_core_irq_in) begin
			pulses <= pulses + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////

	// One-cycle pulse of a single source, launched just after an edge.
	task automatic fire(input int k);
		irq_vec_pkg::irq_events_s ev;
		ev = '0;
		case (k)
			0: ev.ext_pin_irq_zero = 1'b1;
			1: ev.ext_pin_irq_one = 1'b1;
			2: ev.timer_irq = 1'b1;
			3: ev.port0_rx_irq = 1'b1;
			4: ev.port0_tx_irq = 1'b1;
			5: ev.port2_rx_irq = 1'b1;
			6: ev.dma_done_irq[0] = 1'b1;
			7: ev.port2_tx_irq = 1'b1;
			8: ev.dma_done_irq[1] = 1'b1;
			9: ev.host_port_irq = 1'b1;
			10: ev.port1_rx_irq = 1'b1;
			11: ev.dma_done_irq[2] = 1'b1;
			12: ev.port1_tx_irq = 1'b1;
			13: ev.dma_done_irq[3] = 1'b1;
			14: ev.dma_done_irq[4] = 1'b1;
			15: ev.dma_done_irq[5] = 1'b1;
			default: ev.cross_core_irq = 1'b1;
		endcase
		@(posedge ref_clk);
		events <= ev;
		@(posedge ref_clk);
		events <= '0;
	endtask : fire
endmodule : far_side_model

`default_nettype wire

// ### test_dual_core_interrupt_vectoring.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
	$display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end

module test_dual_core_interrupt_vectoring;
	logic                      ref_clk;
	logic                      rst_b;
	logic [7:0]                avs_address;
	logic                      avs_read;
	logic                      avs_write;
	logic [31:0]               avs_writedata;
	logic [3:0]                avs_byteenable;
	logic [3:0]                lanes;
	logic [31:0]               avs_readdata;
	logic                      avs_waitrequest;
	irq_vec_pkg::irq_events_s  events;
	logic                      sw_reset;
	logic                      nmi;
	logic                      core_ack;
	irq_vec_pkg::vector_s      vector;
	logic                      irq;
	logic                      cross_core_irq_out;
	int                        err_count;
	int                        checked;
	int                        cyc;
	int                        p0;
	int                        bt [17] = '{0, 1, 3, 4, 5, 6, 6, 7, 7, 9,
		10, 10, 11, 11, 12, 13, 14};
	logic                      rte [17] = '{0, 0, 0, 0, 0, 0, 1, 0, 1, 0,
		0, 1, 0, 1, 0, 0, 0};
	logic [4:0]                pr [17] = '{5'h03, 5'h04, 5'h06, 5'h07,
		5'h08, 5'h09, 5'h09, 5'h0A, 5'h0A, 5'h0C, 5'h0D, 5'h0D, 5'h0E,
		5'h0E, 5'h0F, 5'h10, 5'h11};
	logic [7:0]                lc [17] = '{8'h40, 8'h44, 8'h4C, 8'h50,
		8'h54, 8'h58, 8'h58, 8'h5C, 8'h5C, 8'h64, 8'h68, 8'h68, 8'h6C,
		8'h6C, 8'h70, 8'h74, 8'h78};

	irq_vectoring u_irq_vectoring (
		.ref_clk            (ref_clk),
		.rst_b              (rst_b),
		.avs_address        (avs_address),
		.avs_read           (avs_read),
		.avs_write          (avs_write),
		.avs_writedata      (avs_writedata),
		.avs_byteenable     (avs_byteenable),
		.avs_readdata       (avs_readdata),
		.avs_waitrequest    (avs_waitrequest),
		.events             (events),
		.sw_reset           (sw_reset),
		.nmi                (nmi),
		.core_ack           (core_ack),
		.vector             (vector),
		.irq                (irq),
		.cross_core_irq_out (cross_core_irq_out)
	);

	far_side_model u_far_side_model (
		.ref_clk           (ref_clk),
		.rst_b             (rst_b),
		.cross_core_irq_in (cross_core_irq_out),
		.events            (events)
	);

	always #20 ref_clk = ~ref_clk;

	// The run takes well under a thousand cycles; this only catches a hang.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////

	task automatic conclude();
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	// The request stands until the rising edge that sees waitrequest low;
	// the write lands and read data is taken at that edge, no earlier.
	// A hang is left to the cycle ceiling rather than a local limit.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= lanes;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wreg

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask : rchk

	task automatic strobe(input int w);
		@(posedge ref_clk);
		if (w == 0) core_ack <= 1'b1;
		else if (w == 1) nmi <= 1'b1;
		else sw_reset <= 1'b1;
		@(posedge ref_clk);
		core_ack <= 1'b0;
		nmi <= 1'b0;
		sw_reset <= 1'b0;
	endtask : strobe

	task automatic settle();
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle

	task automatic vchk(input logic v, input int p, input logic [7:0] l);
		`CHK(vector.valid, v)
		`CHK(irq, v)
		if (v) `CHK({vector.prio, vector.loc}, {5'(p), l})
	endtask : vchk

	task automatic ack();
		strobe(0);
		settle();
	endtask : ack

	////////////////////////////////////////////////////////////////////////

	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		lanes = 4'hF;
		{sw_reset, nmi, core_ack} = '0;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		vchk(1'b1, 1, 8'h00);
		ack();
		vchk(1'b0, 0, 8'h00);
		rchk(irq_vec_pkg::OFS_MASK, 32'h0000_0000);
		rchk(irq_vec_pkg::OFS_FLAGS, 32'h0000_0000);
		wreg(irq_vec_pkg::OFS_MASK, 32'h0000_FFFF);
		rchk(irq_vec_pkg::OFS_MASK, 32'h0000_7EFB);
		// Only the upper byte lane is enabled, so the lower byte survives.
		lanes = 4'h2;
		wreg(irq_vec_pkg::OFS_MASK, 32'h0000_0000);
		lanes = 4'hF;
		rchk(irq_vec_pkg::OFS_MASK, 32'h0000_00FB);
		wreg(irq_vec_pkg::OFS_MASK, 32'h0000_FFFF);
		wreg(8'h1C, 32'h0000_FFFF);
		rchk(8'h1C, 32'h0000_0000);
		// Every source, shared slots taken once per route choice.
		for (int k = 0; k < 17; k++) begin
			wreg(irq_vec_pkg::OFS_ROUTE, rte[k] ? 32'hF : 32'h0);
			u_far_side_model.fire(k);
			rchk(irq_vec_pkg::OFS_FLAGS, 32'(1) << bt[k]);
			vchk(1'b1, pr[k], lc[k]);
			ack();
			vchk(1'b0, 0, 8'h00);
			rchk(irq_vec_pkg::OFS_FLAGS, 32'h0);
		end
		wreg(irq_vec_pkg::OFS_ROUTE, 32'h0);
		u_far_side_model.fire(6);
		rchk(irq_vec_pkg::OFS_FLAGS, 32'h0);
		wreg(irq_vec_pkg::OFS_ROUTE, 32'hF);
		u_far_side_model.fire(10);
		rchk(irq_vec_pkg::OFS_FLAGS, 32'h0);
		wreg(irq_vec_pkg::OFS_ROUTE, 32'h0);
		u_far_side_model.fire(2);
		u_far_side_model.fire(1);
		settle();
		vchk(1'b1, 4, 8'h44);
		ack();
		vchk(1'b1, 6, 8'h4C);
		wreg(irq_vec_pkg::OFS_MASK, 32'h0);
		settle();
		vchk(1'b0, 0, 8'h00);
		rchk(irq_vec_pkg::OFS_FLAGS, 32'h0000_0008);
		wreg(irq_vec_pkg::OFS_CLEAR, 32'h0000_0008);
		rchk(irq_vec_pkg::OFS_FLAGS, 32'h0);
		strobe(1);
		settle();
		vchk(1'b1, 2, 8'h04);
		ack();
		strobe(2);
		settle();
		vchk(1'b1, 1, 8'h00);
		ack();
		u_far_side_model.fire(0);
		wreg(irq_vec_pkg::OFS_FLAGS, 32'h0000_0001);
		rchk(irq_vec_pkg::OFS_FLAGS, 32'h0);
		// Cross-core requests: only a fresh one after a zero raises a pulse.
		p0 = u_far_side_model.pulses;
		wreg(irq_vec_pkg::OFS_BSC, 32'h1);
		repeat (3) @(posedge ref_clk);
		`CHK(u_far_side_model.pulses, p0 + 1)
		rchk(irq_vec_pkg::OFS_BSC, 32'h1);
		rchk(irq_vec_pkg::OFS_FLAGS, 32'h0);
		wreg(irq_vec_pkg::OFS_BSC, 32'h1);
		repeat (3) @(posedge ref_clk);
		`CHK(u_far_side_model.pulses, p0 + 1)
		wreg(irq_vec_pkg::OFS_BSC, 32'h0);
		wreg(irq_vec_pkg::OFS_BSC, 32'h1);
		repeat (3) @(posedge ref_clk);
		`CHK(u_far_side_model.pulses, p0 + 2)
		// A reset in mid-run must bring back the reset vector and clear state.
		rst_b <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		vchk(1'b1, 1, 8'h00);
		rchk(irq_vec_pkg::OFS_MASK, 32'h0000_0000);
		rchk(irq_vec_pkg::OFS_BSC, 32'h0000_0000);
		conclude();
	end
endmodule : test_dual_core_interrupt_vectoring

`default_nettype wire
